// ---- rtl/comparator_pkg.sv ----
package comparator_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] FLAG_INDEX = 10'h00C;
    localparam logic [9:0] FIRST_INDEX = 10'h019;
    localparam logic [9:0] SECOND_INDEX = 10'h01A;
    localparam logic [9:0] PORT_INDEX = 10'h005;
    localparam logic [9:0] DIRECTION_INDEX = 10'h085;

    // first control register fields
    localparam int MODE_LSB = 0;
    localparam int INPUT_SWITCH_BIT = 3;
    localparam int INVERT_BIT = 4;
    localparam int RESULT_BIT = 6;
    localparam logic [7:0] FIRST_WRITE_MASK = 8'h1F;
    localparam logic [7:0] FIRST_RESET = 8'h00;

    // second control register fields
    localparam int SYNC_ENABLE_BIT = 0;
    localparam int GATE_SELECT_BIT = 1;
    localparam logic [7:0] SECOND_WRITE_MASK = 8'h03;
    localparam logic [7:0] SECOND_RESET = 8'h02;

    // peripheral flag register
    localparam int CHANGE_FLAG_BIT = 3;

    // port pins
    localparam int PIN_COUNT = 6;
    localparam int POSITIVE_PIN = 0;
    localparam int NEGATIVE_PIN = 1;
    localparam int OUTPUT_PIN = 2;
    localparam int GATE_PIN = 4;
    localparam logic [5:0] PORT_RESET = 6'h00;
    localparam logic [5:0] DIRECTION_RESET = 6'h3F;

    // timing
    localparam int CLOCK_MHZ = 50;
    localparam int MODE_SETTLE_NS = 10000;
    localparam int MODE_SETTLE_CYCLES = (MODE_SETTLE_NS * CLOCK_MHZ) / 1000;

    typedef enum logic [2:0]
    {
        MODE_RESET = 3'h0,
        MODE_PINS_OUT = 3'h1,
        MODE_REF_NO_OUT = 3'h2,
        MODE_REF_OUT = 3'h3,
        MODE_PINS_NO_OUT = 3'h4,
        MODE_MUX_REF_OUT = 3'h5,
        MODE_MUX_REF_NO_OUT = 3'h6,
        MODE_OFF = 3'h7
    } mode_type;

    typedef struct packed
    {
        logic valid;
        logic write;
        logic [9:0] index;
    } bus_request_type;

    // steering for the analog front end
    typedef struct packed
    {
        logic enable;
        logic negativeIsReference;
        logic positiveFromNegativePin;
        logic drivesPin;
    } analog_control_type;

endpackage

// ---- rtl/comparator_mode_output_control.sv ----
// What this block does
// - Port reads return zero on pins 0 and 1 in every mode, except pin 0 in mode 011.
// - Three-bit mode field in first control register selects eight modes.
// - Result may be invalid for a settling delay after mode change.
// - Modes 000 and 111 turn comparator off; result reads zero.
// - Mode 010 uses reference, 100 uses two pins; neither drives pin.
// - Mode 011 uses reference, 001 uses two pins; both drive pin.
// - Modes 101/110 compare reference to switch-selected pin; 101 drives pin.
// - Result bit in first control register is read-only.
// - Output pin carries the result unsynchronized when a driving mode is set.
// - Pin direction bit still gates the output driver.
// - Invert bit 4 of first register flips result polarity.
// - Second register bit 1 picks gate pin (1) or result (0); resets 1.
// - Sync enable bit 0 latches result on timer clock falling edge; resets 0.
// - With prescaler, latch uses prescaler output falling edge.
// - Timer counts on rising edge, latch on falling edge: no race.
// - Second register bits 7..2 read zero and ignore writes.
// - Change flag bit 3 sets while result differs from last latched value.
// - Any access to first register refreshes latched reference value.
// - Uninverted result is 1 when positive input exceeds negative input.
// - Reset returns control registers to reset values, mode 000.
`timescale 1ns/10ps
`default_nettype none

module comparator_mode_output_control
    import comparator_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // analog comparator
    input wire logic rawCompare,
    output analog_control_type analogControl,
    // port pins
    input wire logic [5:0] pinIn,
    output logic [5:0] pinOut,
    output logic [5:0] pinOe,
    // gated sixteen bit counter interface
    input wire logic timerClock,
    input wire logic prescalerOut,
    input wire logic prescalerUsed,
    output logic timerGate
);

    bus_request_type request;
    logic [2:0] modeSelect;
    logic inputSwitch;
    logic resultInvert;
    logic gateSourceSelect;
    logic syncEnable;
    logic changeFlag;
    logic lastLatched;
    logic [5:0] portLatch;
    logic [5:0] pinDirection;
    logic syncStage1;
    logic syncStage2;
    logic compareResult;
    logic latchedResult;
    logic latchClockPrev;
    logic latchClock;
    logic [15:0] settleCount;
    logic settling;
    logic firstAccess;
    logic writeFirst;
    logic writeSecond;
    logic writeFlag;
    logic writePort;
    logic writeDirection;
    logic [5:0] analogMask;
    logic next_changeFlag;

    // mode decode used for both the analog front end and pin routing
    function automatic analog_control_type decodeMode(input logic [2:0] mode, input logic switchSel);
        analog_control_type c;
        c = '0;
        case (mode)
            MODE_RESET, MODE_OFF:
            begin
                c = '0;
            end
            MODE_REF_NO_OUT:
            begin
                c.enable = 1'b1;
                c.negativeIsReference = 1'b1;
            end
            MODE_PINS_NO_OUT:
            begin
                c.enable = 1'b1;
            end
            MODE_REF_OUT:
            begin
                c.enable = 1'b1;
                c.negativeIsReference = 1'b1;
                c.drivesPin = 1'b1;
            end
            MODE_PINS_OUT:
            begin
                c.enable = 1'b1;
                c.drivesPin = 1'b1;
            end
            MODE_MUX_REF_OUT, MODE_MUX_REF_NO_OUT:
            begin
                c.enable = 1'b1;
                c.negativeIsReference = 1'b1;
                c.positiveFromNegativePin = ~switchSel;
                c.drivesPin = (mode == MODE_MUX_REF_OUT);
            end
            default:
            begin
                c = '0;
            end
        endcase
        return c;
    endfunction

    assign analogControl = decodeMode(modeSelect, inputSwitch);

    // bus slave: always ready, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            request <= '0;
        end
        else if (hready)
        begin
            request.valid <= hsel & htrans[1];
            request.write <= hwrite;
            request.index <= haddr[11:2];
        end
    end

    assign firstAccess = request.valid && (request.index == FIRST_INDEX);
    assign writeFirst = firstAccess && request.write;
    assign writeSecond = request.valid && request.write && (request.index == SECOND_INDEX);
    assign writeFlag = request.valid && request.write && (request.index == FLAG_INDEX);
    assign writePort = request.valid && request.write && (request.index == PORT_INDEX);
    assign writeDirection = request.valid && request.write && (request.index == DIRECTION_INDEX);

    // first control register
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            modeSelect <= FIRST_RESET[MODE_LSB +: 3];
            inputSwitch <= FIRST_RESET[INPUT_SWITCH_BIT];
            resultInvert <= FIRST_RESET[INVERT_BIT];
        end
        else if (writeFirst)
        begin
            // result bit position is not stored, writes there are dropped
            modeSelect <= hwdata[MODE_LSB +: 3];
            inputSwitch <= hwdata[INPUT_SWITCH_BIT];
            resultInvert <= hwdata[INVERT_BIT];
        end
    end

    // second control register, only two bits exist
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            gateSourceSelect <= SECOND_RESET[GATE_SELECT_BIT];
            syncEnable <= SECOND_RESET[SYNC_ENABLE_BIT];
        end
        else if (writeSecond)
        begin
            gateSourceSelect <= hwdata[GATE_SELECT_BIT];
            syncEnable <= hwdata[SYNC_ENABLE_BIT];
        end
    end

    // port latch and direction (1 = input)
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            portLatch <= PORT_RESET;
            pinDirection <= DIRECTION_RESET;
        end
        else
        begin
            if (writePort)
            begin
                portLatch <= hwdata[PIN_COUNT-1:0];
            end
            if (writeDirection)
            begin
                pinDirection <= hwdata[PIN_COUNT-1:0];
            end
        end
    end

    // two-flop synchronizer on the raw comparator output
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            syncStage1 <= 1'b0;
            syncStage2 <= 1'b0;
        end
        else
        begin
            syncStage1 <= rawCompare;
            syncStage2 <= syncStage1;
        end
    end

    // analog front end reports positive above negative as 1
    assign compareResult = analogControl.enable & (syncStage2 ^ resultInvert);

    // hold off change detection while the comparator settles after a mode write
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            settleCount <= '0;
        end
        else if (writeFirst && (hwdata[MODE_LSB +: 3] != modeSelect))
        begin
            settleCount <= 16'(MODE_SETTLE_CYCLES);
        end
        else if (settleCount != '0)
        begin
            settleCount <= settleCount - 16'h0001;
        end
    end

    assign settling = (settleCount != '0);

    // mismatch reference: refreshed by any access to the first register
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            lastLatched <= 1'b0;
        end
        else if (firstAccess || settling)
        begin
            lastLatched <= compareResult
                ^ (writeFirst & analogControl.enable & (hwdata[INVERT_BIT] ^ resultInvert));
        end
    end

    // a mismatch beats a software clear in the same cycle
    always_comb
    begin
        next_changeFlag = changeFlag;
        if (writeFlag)
        begin
            next_changeFlag = hwdata[CHANGE_FLAG_BIT];
        end
        if (!settling && !firstAccess && (compareResult != lastLatched))
        begin
            next_changeFlag = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            changeFlag <= 1'b0;
        end
        else
        begin
            changeFlag <= next_changeFlag;
        end
    end

    // falling edge of the timer clock, or of the prescaler output when in use;
    // the counter itself advances on the rising edge so capture never races it
    assign latchClock = prescalerUsed ? prescalerOut : timerClock;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            latchClockPrev <= 1'b0;
            latchedResult <= 1'b0;
        end
        else
        begin
            latchClockPrev <= latchClock;
            if (latchClockPrev && !latchClock)
            begin
                latchedResult <= compareResult;
            end
        end
    end

    assign timerGate = gateSourceSelect ? pinIn[GATE_PIN] : (syncEnable ? latchedResult : compareResult);

    // analog pins per mode; only reference-with-output frees the positive pin
    always_comb
    begin
        analogMask = '0;
        analogMask[NEGATIVE_PIN] = 1'b1;
        analogMask[POSITIVE_PIN] = (modeSelect != MODE_REF_OUT);
    end

    // raw comparator path to the pin, no clock in the way, so threshold glitches reach it
    always_comb
    begin
        pinOut = portLatch;
        pinOut[OUTPUT_PIN] = analogControl.drivesPin ?
            (analogControl.enable & (rawCompare ^ resultInvert)) : portLatch[OUTPUT_PIN];
        pinOe = ~pinDirection;
    end

    // read data
    always_comb
    begin
        hrdata = '0;
        if (request.valid && !request.write)
        begin
            case (request.index)
                FIRST_INDEX:
                begin
                    hrdata[MODE_LSB +: 3] = modeSelect;
                    hrdata[INPUT_SWITCH_BIT] = inputSwitch;
                    hrdata[INVERT_BIT] = resultInvert;
                    hrdata[RESULT_BIT] = compareResult;
                end
                SECOND_INDEX:
                begin
                    hrdata[GATE_SELECT_BIT] = gateSourceSelect;
                    hrdata[SYNC_ENABLE_BIT] = syncEnable;
                end
                FLAG_INDEX:
                begin
                    hrdata[CHANGE_FLAG_BIT] = changeFlag;
                end
                PORT_INDEX:
                begin
                    hrdata[PIN_COUNT-1:0] = pinIn & ~analogMask;
                end
                DIRECTION_INDEX:
                begin
                    hrdata[PIN_COUNT-1:0] = pinDirection;
                end
                default:
                begin
                    hrdata = '0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- verif/comparator_checker_properties.sv ----
`timescale 1ns/10ps
`default_nettype none

module comparator_checker
    import comparator_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // comparator, pins and gate
    input wire logic rawCompare,
    input wire analog_control_type analogControl,
    input wire logic [5:0] pinIn,
    input wire logic [5:0] pinOut,
    input wire logic [5:0] pinOe,
    input wire logic timerGate
);
    logic dpRead;
    logic dpWrite;
    logic [9:0] dpIndex;

    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);

    // track the data phase so read data can be tied to its address
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            dpRead <= 1'b0;
            dpWrite <= 1'b0;
            dpIndex <= 10'h000;
        end
        else if (hready)
        begin
            dpRead <= hsel && htrans[1] && !hwrite;
            dpWrite <= hsel && htrans[1] && hwrite;
            dpIndex <= haddr[11:2];
        end
    end

    property p_pin_direct;
        analogControl.drivesPin && $stable(analogControl) && $changed(rawCompare) |-> $changed(pinOut[2]);
    endproperty
    a_pin_direct: assert property (p_pin_direct)
        else $error("pin 2 missed a result change");

    property p_reset_mode;
        $past(reset) |-> !analogControl.enable && !analogControl.drivesPin;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("comparator enabled after reset");

    property p_gate_reset;
        $past(reset) |-> timerGate == pinIn[4];
    endproperty
    a_gate_reset: assert property (p_gate_reset)
        else $error("gate not from gate pin after reset");

    property p_oe_write;
        $changed(pinOe) |-> $past(dpWrite) && $past(dpIndex) == DIRECTION_INDEX;
    endproperty
    a_oe_write: assert property (p_oe_write)
        else $error("pin enables changed without a direction write");

    property p_second_zero;
        dpRead && dpIndex == SECOND_INDEX |-> hrdata[31:2] == 30'h0;
    endproperty
    a_second_zero: assert property (p_second_zero)
        else $error("unused second control bits read nonzero");

    property p_first_zero;
        dpRead && dpIndex == FIRST_INDEX |-> hrdata[31:7] == 25'h0 && !hrdata[5];
    endproperty
    a_first_zero: assert property (p_first_zero)
        else $error("unused first control bits read nonzero");

    property p_off_result;
        dpRead && dpIndex == FIRST_INDEX && !analogControl.enable |-> !hrdata[RESULT_BIT];
    endproperty
    a_off_result: assert property (p_off_result)
        else $error("result reads one while comparator off");

    property p_port_analog;
        dpRead && dpIndex == PORT_INDEX |-> !hrdata[1];
    endproperty
    a_port_analog: assert property (p_port_analog)
        else $error("analog pin reads one on port");
endmodule

`default_nettype wire

// ---- verif/analog_front_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module analog_front_model
    import comparator_pkg::*;
(
    // steering from the block
    input wire analog_control_type analogControl,
    // analog levels
    input wire logic [7:0] positiveLevel,
    input wire logic [7:0] negativeLevel,
    input wire logic [7:0] referenceLevel,
    // raw result
    output logic rawCompare
);
    logic [7:0] plusSide;
    logic [7:0] minusSide;

    assign plusSide = analogControl.positiveFromNegativePin ? negativeLevel : positiveLevel;
    assign minusSide = analogControl.negativeIsReference ? referenceLevel : negativeLevel;
    // a powered-down comparator settles low
    assign rawCompare = analogControl.enable && (plusSide > minusSide);
endmodule

`default_nettype wire

// ---- verif/comparator_mode_output_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module comparator_mode_output_control_tb
    import comparator_pkg::*;
;
    localparam logic [3:0] CTRL_EXP [16] = '{4'h0, 4'h0, 4'h9, 4'h9, 4'hC, 4'hC, 4'hD, 4'hD,
        4'h8, 4'h8, 4'hF, 4'hD, 4'hE, 4'hC, 4'h0, 4'h0};
    logic clock, reset, hsel, hwrite, hreadyout, hresp, rawCompare, timerClock, prescalerOut, prescalerUsed;
    logic timerGate, readPhase;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, readMask;
    logic [5:0] pinIn, pinOut, pinOe;
    logic [7:0] pos, neg, refl;
    logic [2:0] m;
    logic v;
    analog_control_type analogControl;
    logic [31:0] expVal[$];
    logic [31:0] expMask[$];
    int fails, checked;

    comparator_mode_output_control i_comparator_mode_output_control (.clock(clock), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rawCompare(rawCompare),
        .analogControl(analogControl), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .timerClock(timerClock),
        .prescalerOut(prescalerOut), .prescalerUsed(prescalerUsed), .timerGate(timerGate));
    analog_front_model i_analog_front_model (.analogControl(analogControl), .positiveLevel(pos),
        .negativeLevel(neg), .referenceLevel(refl), .rawCompare(rawCompare));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wait_ready;
        int n;
        @(posedge clock);
        for (n = 0; n < 50 && hreadyout !== 1'b1; n++)
            @(posedge clock);
        if (hreadyout !== 1'b1)
        begin
            chk("bus wait", 32'h1, 32'h0);
            test_done();
        end
    endtask

    // single word transfer; reads leave their expectation for the monitor
    task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd, input logic [31:0] ev,
        input logic [31:0] em);
        hwrite <= wr;
        htrans <= 2'h2;
        haddr <= {20'h00000, idx, 2'h0};
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        readPhase <= !wr;
        if (!wr)
        begin
            expVal.push_back(ev);
            expMask.push_back(em);
        end
        wait_ready();
        readPhase <= 1'b0;
    endtask

    task automatic pulse(input logic usePre);
        if (usePre)
            prescalerOut <= 1'b0;
        else
            timerClock <= 1'b0;
        repeat (4) @(posedge clock);
        prescalerOut <= 1'b1;
        timerClock <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    function automatic logic exp_result(input logic [2:0] md, input logic c, input logic inv);
        logic [7:0] a;
        logic [7:0] b;
        a = (md inside {3'h5, 3'h6} && !c) ? neg : pos;
        b = (md inside {3'h1, 3'h4}) ? neg : refl;
        exp_result = (md == 3'h0 || md == 3'h7) ? 1'b0 : ((a > b) ^ inv);
    endfunction

    always @(posedge clock)
    begin
        if (readPhase)
        begin
            readMask = expMask.pop_front();
            chk("hrdata", expVal.pop_front() & readMask, hrdata & readMask);
            chk("hresp", 32'h0, hresp);
        end
    end

    initial
    begin
        {reset, hsel, hwrite, readPhase, timerClock, prescalerOut, prescalerUsed} = 7'h66;
        {htrans, haddr, hwdata, pos, neg, refl, pinIn} = '0;
        fails = 0;
        checked = 0;
        void'($urandom(32'h956A3F26));
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        pinIn <= 6'($urandom);
        bus(0, FIRST_INDEX, 0, 32'h0, 32'hFF);
        bus(0, SECOND_INDEX, 0, 32'h2, 32'hFFFFFFFF);
        bus(0, DIRECTION_INDEX, 0, 32'h3F, 32'h3F);
        bus(0, PORT_INDEX, 0, 32'h0, 32'h3);
        bus(0, 10'h3FF, 0, 32'h0, 32'hFFFFFFFF);
        chk("timerGate", pinIn[4], timerGate);
        bus(1, DIRECTION_INDEX, 32'h3B, 0, 0);
        @(posedge clock);
        chk("pinOe", 32'h04, pinOe);
        bus(1, PORT_INDEX, 32'h15, 0, 0);
        @(posedge clock);
        chk("pinOut", 32'h15, pinOut);
        // every mode with invert and switch both clear, then both set
        for (int k = 0; k < 16; k++)
        begin
            m = k[3:1];
            v = k[0];
            pos <= 8'($urandom);
            neg <= 8'($urandom);
            refl <= 8'($urandom);
            bus(1, FIRST_INDEX, {24'h0, 3'h7, v, v, m}, 0, 0);
            repeat (4) @(posedge clock);
            chk("analogControl", CTRL_EXP[{m, v}], analogControl);
            bus(0, FIRST_INDEX, 0, {exp_result(m, v, v), 1'b0, v, v, m}, 32'hFF);
            bus(0, PORT_INDEX, 0, {pinIn[5:2], 1'b0, (m == 3'h3) & pinIn[0]}, 32'h3F);
            if (m inside {3'h1, 3'h3, 3'h5})
                chk("pinOut2", exp_result(m, v, v), pinOut[2]);
        end
        pos <= 8'h80;
        neg <= 8'h40;
        bus(1, FIRST_INDEX, 32'h1, 0, 0);
        repeat (520) @(posedge clock);
        bus(0, FIRST_INDEX, 0, 32'h41, 32'hFF);
        bus(1, FLAG_INDEX, 32'h0, 0, 0);
        neg <= 8'hC0;
        repeat (6) @(posedge clock);
        bus(0, FLAG_INDEX, 0, 32'h8, 32'h8);
        bus(0, FIRST_INDEX, 0, 32'h01, 32'hFF);
        bus(1, FLAG_INDEX, 32'h0, 0, 0);
        bus(0, FLAG_INDEX, 0, 32'h0, 32'h8);
        bus(1, SECOND_INDEX, 32'hFF, 0, 0);
        bus(0, SECOND_INDEX, 0, 32'h3, 32'hFFFFFFFF);
        chk("timerGate", pinIn[4], timerGate);
        bus(1, SECOND_INDEX, 32'h1, 0, 0);
        pulse(1'b0);
        chk("timerGate", 32'h0, timerGate);
        neg <= 8'h40;
        repeat (6) @(posedge clock);
        chk("timerGate", 32'h0, timerGate);
        pulse(1'b0);
        chk("timerGate", 32'h1, timerGate);
        prescalerUsed <= 1'b1;
        neg <= 8'hC0;
        pulse(1'b0);
        chk("timerGate", 32'h1, timerGate);
        pulse(1'b1);
        chk("timerGate", 32'h0, timerGate);
        bus(1, SECOND_INDEX, 32'h0, 0, 0);
        neg <= 8'h40;
        repeat (6) @(posedge clock);
        chk("timerGate", 32'h1, timerGate);
        test_done();
    end
endmodule

bind comparator_mode_output_control comparator_checker i_comparator_checker (.clock(clock), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .rawCompare(rawCompare), .analogControl(analogControl), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .timerGate(timerGate));

`default_nettype wire
